// ==== gcg_defines.vh ====
// constants for the graphics host configuration glue
`ifndef GCG_DEFINES_VH
`define GCG_DEFINES_VH
// i/o ports of the standard register set
`define GCG_P_MISC_W   16'h03c2
`define GCG_P_ISR0     16'h03c2
`define GCG_P_MISC_R   16'h03cc
`define GCG_P_FC_W     16'h03da
`define GCG_P_FC_R     16'h03ca
`define GCG_P_CRT_I    16'h03d4
`define GCG_P_CRT_D    16'h03d5
`define GCG_CRT_IRQCLR 8'h11
// palette ports, normal and extension window
`define GCG_P_PAL_MASK 16'h03c6
`define GCG_P_PAL_STAT 16'h03c7
`define GCG_P_PAL_WIDX 16'h03c8
`define GCG_P_PAL_DATA 16'h03c9
`define GCG_P_PALX_LO  16'h83c6
`define GCG_P_PALX_ST  16'h83c7
`define GCG_P_PALX_HI  16'h83c9
`define GCG_DAC_RDMODE 2'h3
`define GCG_DAC_WRMODE 2'h0
// extension unlock ports and bits, extension index/data ports
`define GCG_P_EXT_A    16'h46e8
`define GCG_B_EXT_A    4
`define GCG_P_EXT_B    16'h0103
`define GCG_B_EXT_B    7
`define GCG_P_XIDX     16'h03d6
`define GCG_P_XDAT     16'h03d7
// extension register indices
`define GCG_XR_ENABLE  8'h00
`define GCG_XR_SWITCH  8'h01
`define GCG_XR_GPO     8'h02
`define GCG_XR_DEFV    8'h03
`define GCG_XR_VCTL    8'h04
`define GCG_XR_FRAME   8'h05
// field positions
`define GCG_EN_IDCHK   4
`define GCG_EN_PALX    5
`define GCG_VC_FORCE   0
`define GCG_VC_IRQPOL  7
`define GCG_FR_IRQEN   7
// rom window is addr[19:15] == this value (c0000-c7fff)
`define GCG_ROM_BASE   5'h18
// cycles the muxed switch pins get to settle after address phase
`define GCG_SETTLE     2'h2
// general purpose output modes
`define GCG_GP_NORMAL  2'h0
`define GCG_GP_HIZ     2'h1
`define GCG_GP_LOW     2'h2
`define GCG_GP_HIGH    2'h3
// reset values
`define GCG_RST_BYTE   8'h00
`endif

// ==== gcg_host_glue.v ====
// host bus glue and configuration logic of the graphics controller
`timescale 1ns/1ns
`include "gcg_defines.vh"
module gcg_host_glue (
   input  wire        clk,                 // 20 mhz system clock
   input  wire        rst_n,               // synchronous reset
   input  wire        busIsPc,             // strap: 1 pc/at, 0 channel
   input  wire [19:0] hostAddr,            // address, switches on 18:16
   input  wire [15:0] hostDataIn,          // data from host bus
   input  wire        ioReadStrobe_n,      // i/o read or channel cmd
   input  wire        ioWriteStrobe_n,     // i/o write
   input  wire        memRead_n,           // memory read or status 1
   input  wire        memWrite_n,          // memory write or status 0
   input  wire        byteHigh_n,          // byte-high enable, switch
   input  wire        memoryNotIo,         // aen or memory/io, switch
   input  wire        controllerDisable_n, // refresh or disable, switch
   input  wire        highAddressHit,      // high address decode, switch
   input  wire        featureIn0,          // feature connector input 0
   input  wire        featureIn1,          // feature connector input 1
   input  wire        vsync,               // frame sync from crt timing
   input  wire [3:0]  gpNormal,            // normal functions of gp pins
   output reg         addrEnable_n,        // 0 address phase, 1 data
   output reg         readHigh_n,          // high transceiver direction
   output reg         readLow_n,           // low transceiver direction
   output reg  [15:0] hostDataOut,         // read data to host
   output reg         hostDataOe,          // drive read data
   output reg         rdyOut,              // ready level
   output reg         rdyOe,               // ready driven
   output reg         ioWide_n,            // word-capable i/o cycle
   output reg         romSelect_n,         // rom chip select
   output reg         paletteRead_n,       // palette read strobe
   output reg         paletteWrite_n,      // palette write strobe
   output reg         irqOut,              // frame interrupt pin
   output reg  [2:0]  dotClockEnable,      // one-hot dot clock pick
   output reg         gpOutA,              // general output a (trap)
   output reg         gpOutAOe,            // drive enable a
   output reg         gpOutB,              // general output b
   output reg         gpOutBOe,            // drive enable b
   output reg         gpOutC,              // general output c
   output reg         gpOutCOe,            // drive enable c
   output reg         gpOutD,              // general output d
   output reg         gpOutDOe,            // drive enable d
   output reg         videoForce,          // hold video at default
   output reg  [7:0]  videoDefault,        // forced video value
   output reg         featureOut0_n,       // feature output 0
   output reg         featureOut1_n,       // feature output 1
   output reg         extActive            // extensions unlocked
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_END  = 2'h3;
   localparam PW = 47;

   reg [PW-1:0] pinS1_q;
   reg [PW-1:0] pinS2_q;
   reg          busPc_q;
   reg [1:0]    state_q;
   reg [1:0]    settle_q;
   reg [19:0]   cyAddr_q;
   reg          cyRead_q;
   reg          cyIo_q;
   reg          cyWide_q;
   reg          cyHit_q;
   reg          cyBcast_q;
   reg          extA_q;
   reg          extB_q;
   reg [7:0]    misc_q;
   reg [7:0]    fc_q;
   reg [7:0]    crtIdx_q;
   reg [7:0]    xIdx_q;
   reg [7:0]    xEnable_q;
   reg [7:0]    xSwitch_q;
   reg [7:0]    xGpo_q;
   reg [7:0]    xDefv_q;
   reg [7:0]    xVctl_q;
   reg [7:0]    xFrame_q;
   reg [1:0]    dacState_q;
   reg          vsyncPrev_q;
   reg [4:0]    frameCnt_q;
   reg          irqPend_q;
   integer      i;

   // synchronised pin copies
   wire [19:0] sAddr  = pinS2_q[19:0];
   wire [15:0] sData  = pinS2_q[35:20];
   wire        sIoR_n = pinS2_q[36];
   wire        sIoW_n = pinS2_q[37];
   wire        sMemR_n = pinS2_q[38];
   wire        sMemW_n = pinS2_q[39];
   wire        sBhe_n = pinS2_q[40];
   wire        sMio   = pinS2_q[41];
   wire        sDis_n = pinS2_q[42];
   wire        sHit   = pinS2_q[43];
   wire        sStrap = pinS2_q[44];
   wire        sFin0  = pinS2_q[45];
   wire        sFin1  = pinS2_q[46];

   wire extOn    = extA_q & extB_q;
   wire selected = ~xEnable_q[`GCG_EN_IDCHK] |
                   (xEnable_q[3:0] == xSwitch_q[3:0]);
   wire palExt   = xEnable_q[`GCG_EN_PALX];

   reg  strobeAct;
   reg  isRead;
   reg  isWrite;
   reg  isIo;
   reg  isMem;
   reg  ioClaim;
   reg  romClaim;
   reg  bcast;
   reg  palette_read_n;
   reg  palette_write_n;

   // port set this controller answers on
   function ourPort;
      input [15:0] a;
      begin
         case (a)
            `GCG_P_MISC_W, `GCG_P_MISC_R, `GCG_P_FC_W, `GCG_P_FC_R,
            `GCG_P_CRT_I, `GCG_P_CRT_D, `GCG_P_PAL_STAT,
            `GCG_P_EXT_A, `GCG_P_EXT_B, `GCG_P_XIDX,
            `GCG_P_XDAT: ourPort = 1'b1;
            default: ourPort = 1'b0;
         endcase
      end
   endfunction

   // palette window match; reads skip the state port
   function palPort;
      input [15:0] a;
      input        rd;
      input        ext;
      begin
         palPort = ((a >= `GCG_P_PAL_MASK) && (a <= `GCG_P_PAL_DATA) &&
                    !(rd && a == `GCG_P_PAL_STAT)) ||
                   (ext && (a >= `GCG_P_PALX_LO) &&
                    (a <= `GCG_P_PALX_HI) &&
                    !(rd && a == `GCG_P_PALX_ST));
      end
   endfunction

   // extension register read
   function [7:0] xrRead;
      input [7:0] idx;
      begin
         case (idx)
            `GCG_XR_ENABLE: xrRead = xEnable_q;
            `GCG_XR_SWITCH: xrRead = xSwitch_q;
            `GCG_XR_GPO:    xrRead = xGpo_q;
            `GCG_XR_DEFV:   xrRead = xDefv_q;
            `GCG_XR_VCTL:   xrRead = xVctl_q;
            `GCG_XR_FRAME:  xrRead = xFrame_q;
            default:        xrRead = `GCG_RST_BYTE;
         endcase
      end
   endfunction

   // i/o register read, one byte lane
   function [7:0] rdReg;
      input [15:0] a;
      begin
         case (a)
            `GCG_P_ISR0:     rdReg = {1'b0, sFin1, sFin0, 5'h00};
            `GCG_P_MISC_R:   rdReg = misc_q;
            `GCG_P_FC_R:     rdReg = fc_q;
            `GCG_P_CRT_I:    rdReg = crtIdx_q;
            `GCG_P_PAL_STAT: rdReg = {6'h00, dacState_q};
            `GCG_P_EXT_A:    rdReg = {3'h0, extA_q, 4'h0};
            `GCG_P_EXT_B:    rdReg = {extB_q, 7'h00};
            `GCG_P_XIDX:     rdReg = xIdx_q;
            `GCG_P_XDAT:     rdReg = xrRead(xIdx_q);
            default:         rdReg = `GCG_RST_BYTE;
         endcase
      end
   endfunction

   // two-flop synchronisers on the host bus, strap and feature pin inputs
   always @(posedge clk) begin
      pinS1_q <= {featureIn1, featureIn0, busIsPc, highAddressHit,
                  controllerDisable_n, memoryNotIo, byteHigh_n,
                  memWrite_n, memRead_n, ioWriteStrobe_n,
                  ioReadStrobe_n, hostDataIn, hostAddr};
      pinS2_q <= pinS1_q;
   end

   // cycle decode for both bus protocols
   always @* begin
      if (busPc_q) begin
         strobeAct = ~sIoR_n | ~sIoW_n | ~sMemR_n | ~sMemW_n;
         isRead    = ~sIoR_n | ~sMemR_n;
         isWrite   = ~sIoW_n | ~sMemW_n;
         isIo      = (~sIoR_n | ~sIoW_n) & ~sMio;
         isMem     = ~sMemR_n | ~sMemW_n;
      end else begin
         strobeAct = ~sIoR_n;
         isRead    = ~sMemR_n & sMemW_n;
         isWrite   = sMemR_n & ~sMemW_n;
         isIo      = ~sMio;
         isMem     = sMio;
      end
      ioClaim  = isIo & (ourPort({sAddr[15:1], 1'b0}) |
                 ourPort({sAddr[15:1], 1'b1}) |
                 palPort(sAddr[15:0], isRead, palExt));
      romClaim = busPc_q & isMem & isRead &
                 (sAddr[19:15] == `GCG_ROM_BASE);
      bcast    = isIo & isWrite & (sAddr[15:1] == `GCG_P_XIDX >> 1 |
                 sAddr[15:0] == `GCG_P_EXT_A |
                 sAddr[15:0] == `GCG_P_EXT_B);
      palette_read_n    = cyIo_q & cyRead_q &
                 palPort(cyAddr_q[15:0], 1'b1, palExt);
      palette_write_n    = cyIo_q & ~cyRead_q &
                 palPort(cyAddr_q[15:0], 1'b0, palExt);
   end

   // strap capture while reset is held
   always @(posedge clk) begin
      if (!rst_n)
         busPc_q <= sStrap;
   end

   // bus cycle sequencer and register writes
   always @(posedge clk) begin
      if (!rst_n) begin
         state_q   <= ST_IDLE;
         settle_q  <= 2'h0;
         cyAddr_q  <= 20'h00000;
         cyRead_q  <= 1'b0;
         cyIo_q    <= 1'b0;
         cyWide_q  <= 1'b0;
         cyHit_q   <= 1'b0;
         cyBcast_q <= 1'b0;
         extA_q    <= 1'b0;
         extB_q    <= 1'b0;
         misc_q    <= `GCG_RST_BYTE;
         fc_q      <= `GCG_RST_BYTE;
         crtIdx_q  <= `GCG_RST_BYTE;
         xIdx_q    <= `GCG_RST_BYTE;
         xEnable_q <= `GCG_RST_BYTE;
         xSwitch_q <= `GCG_RST_BYTE;
         xGpo_q    <= `GCG_RST_BYTE;
         xDefv_q   <= `GCG_RST_BYTE;
         xVctl_q   <= `GCG_RST_BYTE;
         xFrame_q  <= `GCG_RST_BYTE;
         dacState_q <= `GCG_DAC_WRMODE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (strobeAct) begin
                  cyAddr_q  <= sAddr;
                  cyRead_q  <= isRead;
                  cyIo_q    <= isIo;
                  cyWide_q  <= ~sBhe_n;
                  cyHit_q   <= sDis_n & selected &
                               (isRead | isWrite) &
                               (ioClaim | romClaim);
                  cyBcast_q <= sDis_n & bcast;
                  settle_q  <= 2'h0;
                  state_q   <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               settle_q <= settle_q + 2'h1;
               if (settle_q == `GCG_SETTLE)
                  state_q <= ST_DATA;
            end
            ST_DATA: begin
               if (cyRead_q && strobeAct)
                  xSwitch_q <= {1'b0, sDis_n, sMio, sHit, sBhe_n,
                                sAddr[18:16]};
               if (!cyRead_q && cyIo_q && (cyHit_q || cyBcast_q)) begin
                  for (i = 0; i < 2; i = i + 1) begin
                     if ((i == 0) ? ~cyAddr_q[0]
                                  : (cyAddr_q[0] | cyWide_q)) begin
                        case ({cyAddr_q[15:1], i[0]})
                           `GCG_P_EXT_A:
                              extA_q <= sData[8*i+`GCG_B_EXT_A];
                           `GCG_P_EXT_B:
                              extB_q <= sData[8*i+`GCG_B_EXT_B];
                           `GCG_P_XIDX:
                              xIdx_q <= sData[8*i +: 8];
                           `GCG_P_XDAT:
                              if (extOn && (cyHit_q ||
                                  xIdx_q == `GCG_XR_ENABLE))
                                 case (xIdx_q)
                                    `GCG_XR_ENABLE:
                                       xEnable_q <= sData[8*i +: 8];
                                    `GCG_XR_GPO:
                                       xGpo_q <= sData[8*i +: 8];
                                    `GCG_XR_DEFV:
                                       xDefv_q <= sData[8*i +: 8];
                                    `GCG_XR_VCTL:
                                       xVctl_q <= sData[8*i +: 8];
                                    `GCG_XR_FRAME:
                                       xFrame_q <= sData[8*i +: 8];
                                    default: ;
                                 endcase
                           `GCG_P_MISC_W:
                              if (cyHit_q) misc_q <= sData[8*i +: 8];
                           `GCG_P_FC_W:
                              if (cyHit_q) fc_q <= sData[8*i +: 8];
                           `GCG_P_CRT_I:
                              if (cyHit_q) crtIdx_q <= sData[8*i +: 8];
                           `GCG_P_PAL_STAT:
                              if (cyHit_q) dacState_q <= `GCG_DAC_RDMODE;
                           `GCG_P_PAL_WIDX:
                              if (cyHit_q) dacState_q <= `GCG_DAC_WRMODE;
                           default: ;
                        endcase
                     end
                  end
               end
               state_q <= ST_END;
            end
            ST_END: begin
               if (!strobeAct)
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // host-facing strobes, ready, transceivers and read data
   always @(posedge clk) begin
      if (!rst_n) begin
         addrEnable_n   <= 1'b0;
         readHigh_n     <= 1'b1;
         readLow_n      <= 1'b1;
         hostDataOut    <= 16'h0000;
         hostDataOe     <= 1'b0;
         rdyOut         <= 1'b1;
         rdyOe          <= 1'b0;
         ioWide_n       <= 1'b1;
         romSelect_n    <= 1'b1;
         paletteRead_n  <= 1'b1;
         paletteWrite_n <= 1'b1;
      end else begin
         addrEnable_n   <= (state_q != ST_IDLE);
         rdyOe          <= cyHit_q & (state_q != ST_IDLE);
         rdyOut         <= (state_q == ST_DATA) | (state_q == ST_END);
         ioWide_n       <= ~(busPc_q & cyHit_q & cyIo_q &
                             (state_q != ST_IDLE));
         romSelect_n    <= ~(cyHit_q & ~cyIo_q &
                             (state_q != ST_IDLE));
         paletteRead_n  <= ~(cyHit_q & palette_read_n &
                             (state_q == ST_DATA || state_q == ST_END));
         paletteWrite_n <= ~(cyHit_q & palette_write_n &
                             (state_q == ST_DATA || state_q == ST_END));
         readLow_n      <= ~(cyHit_q & cyRead_q & busPc_q &
                             (state_q != ST_IDLE));
         readHigh_n     <= ~(cyHit_q & cyRead_q & busPc_q & cyWide_q &
                             (state_q != ST_IDLE));
         hostDataOe     <= cyHit_q & cyRead_q & cyIo_q & ~palette_read_n &
                           (state_q == ST_DATA || state_q == ST_END);
         hostDataOut    <= {rdReg({cyAddr_q[15:1], 1'b1}),
                            rdReg({cyAddr_q[15:1], 1'b0})};
      end
   end

   // frame counter and sticky frame interrupt, set wins over clear
   always @(posedge clk) begin
      if (!rst_n) begin
         vsyncPrev_q <= 1'b0;
         frameCnt_q  <= 5'h00;
         irqPend_q   <= 1'b0;
         irqOut      <= 1'b0;
      end else begin
         vsyncPrev_q <= vsync;
         if (!xFrame_q[`GCG_FR_IRQEN])
            frameCnt_q <= 5'h00;
         else if (vsync && !vsyncPrev_q)
            frameCnt_q <= (frameCnt_q == xFrame_q[4:0]) ? 5'h00
                          : frameCnt_q + 5'h01;
         if (xFrame_q[`GCG_FR_IRQEN] && vsync && !vsyncPrev_q &&
             frameCnt_q == xFrame_q[4:0])
            irqPend_q <= 1'b1;
         else if (state_q == ST_DATA && cyHit_q && cyIo_q &&
                  !cyRead_q && crtIdx_q == `GCG_CRT_IRQCLR &&
                  cyAddr_q[15:1] == (`GCG_P_CRT_D >> 1) &&
                  (cyAddr_q[0] | cyWide_q))
            irqPend_q <= 1'b0;
         irqOut <= (irqPend_q & selected) ^
                   xVctl_q[`GCG_VC_IRQPOL];
      end
   end

   // configuration-driven outputs
   always @(posedge clk) begin
      if (!rst_n) begin
         dotClockEnable <= 3'h1;
         videoForce     <= 1'b0;
         videoDefault   <= `GCG_RST_BYTE;
         featureOut0_n  <= 1'b1;
         featureOut1_n  <= 1'b1;
         extActive      <= 1'b0;
      end else begin
         case (misc_q[3:2])
            2'h0:    dotClockEnable <= 3'h1;
            2'h1:    dotClockEnable <= 3'h2;
            default: dotClockEnable <= 3'h4;
         endcase
         videoForce    <= xVctl_q[`GCG_VC_FORCE];
         videoDefault  <= xDefv_q;
         featureOut0_n <= ~fc_q[0];
         featureOut1_n <= ~fc_q[1];
         extActive     <= extOn;
      end
   end

   // drive enable and value of one general purpose pin for its mode
   function [1:0] gpMode;
      input [1:0] m;
      input       n;
      begin
         case (m)
            `GCG_GP_NORMAL: gpMode = {1'b1, n};
            `GCG_GP_HIZ:    gpMode = 2'h0;
            `GCG_GP_LOW:    gpMode = 2'h2;
            default:        gpMode = 2'h3;
         endcase
      end
   endfunction

   // general purpose pin modes, one copy per pin
   wire [3:0] gpVal;
   wire [3:0] gpOe;
   genvar     g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gpPin
         assign {gpOe[g], gpVal[g]} = gpMode(xGpo_q[2*g +: 2], gpNormal[g]);
      end
   endgenerate

   // register the four general purpose pins
   always @(posedge clk) begin
      if (!rst_n) begin
         {gpOutD, gpOutC, gpOutB, gpOutA}         <= 4'h0;
         {gpOutDOe, gpOutCOe, gpOutBOe, gpOutAOe} <= 4'h0;
      end else begin
         {gpOutD, gpOutC, gpOutB, gpOutA}         <= gpVal;
         {gpOutDOe, gpOutCOe, gpOutBOe, gpOutAOe} <= gpOe;
      end
   end
endmodule // gcg_host_glue

// ==== gcg_host_glue_props.sv ====
// port assertions for the host glue
`timescale 1ns/1ns
module gcg_host_glue_props (
   input wire       clk, rst_n, busIsPc,               // clock, reset, strap
   input wire       ioReadStrobe_n, ioWriteStrobe_n,   // io strobes
   input wire       memRead_n, memWrite_n,             // memory strobes
   input wire       rdyOut, rdyOe, addrEnable_n,       // ready, phase
   input wire       romSelect_n, irqOut,               // rom, interrupt
   input wire       paletteRead_n, paletteWrite_n,     // palette strobes
   input wire       readLow_n, hostDataOe, ioWide_n,   // lane, data, wide
   input wire [2:0] dotClockEnable                     // dot clock pick
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // strobes toward rom and palette follow the matching host strobe
   pal_read_a: assert property ($fell(paletteRead_n) |-> !ioReadStrobe_n)
      else $error("palette read outside io read");
   pal_write_a: assert property ($fell(paletteWrite_n) |-> !ioWriteStrobe_n)
      else $error("palette write outside io write");
   rom_sel_a: assert property ($fell(romSelect_n) |-> busIsPc && !memRead_n)
      else $error("rom select outside pc memory read");
   // ready waits, then goes high within a bounded span
   rdy_wait_a: assert property ($rose(rdyOe) |-> !rdyOut ##[1:8] rdyOut)
      else $error("ready never came");
   addr_phase_a: assert property ($rose(rdyOe) |-> ##[0:1] addrEnable_n)
      else $error("address phase not ended");
   clk_pick_a: assert property ($onehot(dotClockEnable))
      else $error("dot clock pick not one-hot");
   // transceiver, wide flag and read data only inside matching cycles
   rd_dir_a: assert property ($fell(readLow_n) |-> busIsPc &&
      !(ioReadStrobe_n && memRead_n))
      else $error("transceiver turned outside pc read");
   io_wide_a: assert property ($fell(ioWide_n) |-> busIsPc &&
      !(ioReadStrobe_n && ioWriteStrobe_n))
      else $error("wide i/o flag outside pc i/o cycle");
   data_oe_a: assert property ($rose(hostDataOe) |->
      !ioReadStrobe_n && paletteRead_n)
      else $error("read data driven outside i/o read");
   // nothing answers while the bus is quiet, and reset leaves irq and rom select off with the first dot clock picked
   idle_quiet_a: assert property ((ioReadStrobe_n && ioWriteStrobe_n &&
      memRead_n && memWrite_n) [*6] |-> paletteRead_n && paletteWrite_n &&
      romSelect_n && !rdyOe)
      else $error("activity without a host cycle");
   reset_off_a: assert property ($rose(rst_n) |-> !irqOut && romSelect_n &&
      dotClockEnable == 3'h1)
      else $error("not idle after reset");
endmodule // gcg_host_glue_props
bind gcg_host_glue gcg_host_glue_props gcg_host_glue_props_i (.*);

// ==== gcg_host_model.sv ====
// host bus model: runs pc/at and channel cycles, plays switch buffers
`timescale 1ns/1ns
module gcg_host_model #(parameter [6:0] SWITCHES = 7'h45) (
   input  wire        clk, addrEnable_n, rdyOut, rdyOe, // clock, phase, ready
   input  wire        readHigh_n,                       // high lane direction
   input  wire        paletteRead_n, paletteWrite_n, romSelect_n, // watched
   input  wire [15:0] hostDataOut,                      // read data
   output wire [19:0] hostAddr,                         // address, switches
   output reg  [15:0] hostDataIn,                       // write data
   output wire        ioReadStrobe_n, ioWriteStrobe_n,  // io strobes
   output wire        memRead_n, memWrite_n,            // memory strobes
   output wire        byteHigh_n, memoryNotIo,          // lane, aen
   output wire        controllerDisable_n, highAddressHit // disable, hit
);
   reg [19:0] addrQ = 20'h00000;
   reg [3:0]  strobeQ = 4'hf;
   reg        ack, palHit, romHit, hiRd;
   reg        wideQ = 1'b0;
   reg [15:0] rdData;
   integer    n;
   initial hostDataIn = 16'h0000;
   // switch buffers take the shared pins in the data phase
   assign hostAddr = addrEnable_n ? {~addrQ[19], SWITCHES[2:0], ~addrQ[15:0]}
                                  : addrQ;
   assign byteHigh_n = addrEnable_n ? SWITCHES[3] : ~wideQ;
   assign highAddressHit = addrEnable_n ? SWITCHES[4] : addrQ[19];
   assign memoryNotIo = addrEnable_n & SWITCHES[5];
   assign controllerDisable_n = ~addrEnable_n | SWITCHES[6];
   assign {memWrite_n, memRead_n, ioWriteStrobe_n, ioReadStrobe_n} = strobeQ;
   // one cycle: hold all until ready is driven and sampled high or 24 clocks pass, then release
   task cyc(input [1:0] kind, input [19:0] a, input [7:0] d);
      cmd(~(4'h1 << kind), a, d);
   endtask
   // raw strobe pattern {mem write, mem read, io write, io read}
   task cmd(input [3:0] s, input [19:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addrQ <= a;
         hostDataIn <= {d, d};
         strobeQ <= s;
         ack = 1'b0;
         for (n = 0; n < 24 && !ack; n = n + 1) begin
            @(posedge clk);
            ack = rdyOe & rdyOut;
         end
         palHit = ~(paletteRead_n & paletteWrite_n);
         romHit = ~romSelect_n;
         rdData = hostDataOut;
         hiRd = ~readHigh_n;
         strobeQ <= 4'hf;
         hostDataIn <= ~{d, d};
         repeat (5) @(posedge clk);
      end
   endtask
endmodule // gcg_host_model

// ==== gcg_testbench.sv ====
// self-checking bench for the host glue
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error at %0t: got %h exp %h", $time, g, e); end end
module testbench;
   logic clk = 0, rst_n = 0, busIsPc = 1, vsync = 0;
   logic featureIn0 = 0, featureIn1 = 0;
   logic [3:0] gpNormal = 4'h5;
   wire [19:0] hostAddr;
   wire [15:0] hostDataIn, hostDataOut;
   wire [7:0]  videoDefault;
   wire [2:0]  dotClockEnable;
   wire ioReadStrobe_n, ioWriteStrobe_n, memRead_n, memWrite_n, byteHigh_n;
   wire memoryNotIo, controllerDisable_n, highAddressHit, addrEnable_n;
   wire readHigh_n, readLow_n, hostDataOe, rdyOut, rdyOe, ioWide_n;
   wire romSelect_n, paletteRead_n, paletteWrite_n, irqOut, videoForce;
   wire gpOutA, gpOutAOe, gpOutB, gpOutBOe, gpOutC, gpOutCOe, gpOutD;
   wire gpOutDOe, featureOut0_n, featureOut1_n, extActive;
   integer error_cnt = 0, compares = 0, i;
   reg [7:0] q8;
   gcg_host_glue gcg_host_glue_i (.*);
   gcg_host_model gcg_host_model_i (.*);
   always #25 clk = ~clk;
   // byte write and read through the host model
   task wr(input [15:0] a, input [7:0] d);
      gcg_host_model_i.cyc(2'h1, {4'h0, a}, d);
   endtask
   task rd(input [15:0] a);
      begin
         gcg_host_model_i.cyc(2'h0, {4'h0, a}, 8'h00);
         q8 = a[0] ? gcg_host_model_i.rdData[15:8]
                   : gcg_host_model_i.rdData[7:0];
      end
   endtask
   task xw(input [7:0] idx, input [7:0] d);
      begin wr(16'h03d6, idx); wr(16'h03d7, d); end
   endtask
   task vs;
      begin vsync <= 1; repeat (3) @(posedge clk); vsync <= 0;
         repeat (3) @(posedge clk); end
   endtask
   task final_report;
      begin
         $display("compares %0d errors %0d", compares, error_cnt);
         if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // tests run in order, each leaving the bus idle
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      `CHK({extActive, dotClockEnable, irqOut, gpOutBOe}, 6'h04)
      xw(8'h03, 8'ha5);
      wr(16'h46e8, 8'h10);
      xw(8'h03, 8'ha5);
      `CHK({extActive, videoDefault}, 9'h000)
      wr(16'h0103, 8'h80);
      xw(8'h03, 8'ha5);
      xw(8'h04, 8'h01);
      `CHK({extActive, videoForce, videoDefault, gpOutB,
         gpOutBOe}, 12'he95)
      for (i = 0; i < 4; i++) begin
         wr(16'h03c2, {i[5:0], 2'b00});
         `CHK(dotClockEnable, (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : 3'h4)
      end
      wr(16'h03da, 8'h01);
      featureIn1 <= 1;
      rd(16'h03c2);
      `CHK({featureOut1_n, featureOut0_n, q8[6:5]}, 4'ha)
      wr(16'h03d6, 8'h01);
      rd(16'h03d7);
      `CHK(q8, 8'h45)
      xw(8'h02, 8'he4);
      `CHK({gpOutA, gpOutAOe, gpOutBOe, gpOutC, gpOutCOe, gpOutD,
         gpOutDOe}, 7'h67)
      gcg_host_model_i.wideQ <= 1'b1;
      rd(16'h03d6);
      `CHK({gcg_host_model_i.hiRd, gcg_host_model_i.rdData}, 17'h1e402)
      gcg_host_model_i.wideQ <= 1'b0;
      $display("config test done");
      wr(16'h03c8, 8'h00);
      `CHK(gcg_host_model_i.palHit, 1'b1)
      rd(16'h03c7);
      `CHK({gcg_host_model_i.palHit, q8}, 9'h000)
      rd(16'h03c9);
      `CHK(gcg_host_model_i.palHit, 1'b1)
      gcg_host_model_i.cyc(2'h2, 20'hc0010, 8'h00);
      `CHK(gcg_host_model_i.romHit, 1'b1)
      xw(8'h05, 8'h81);
      vs;
      `CHK(irqOut, 1'b0)
      vs;
      `CHK(irqOut, 1'b1)
      wr(16'h03d4, 8'h11);
      wr(16'h03d5, 8'h00);
      `CHK(irqOut, 1'b0)
      $display("strobe and irq test done");
      xw(8'h00, 8'h13);
      rd(16'h03cc);
      `CHK(gcg_host_model_i.ack, 1'b0)
      xw(8'h00, 8'h15);
      rd(16'h03cc);
      `CHK({gcg_host_model_i.ack, q8}, 9'h10c)
      $display("select test done");
      // second reset into the channel bus protocol
      busIsPc <= 1'b0;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      gcg_host_model_i.cmd(4'h6, 20'h003c2, 8'h08);
      gcg_host_model_i.cmd(4'ha, 20'h003cc, 8'h00);
      `CHK({gcg_host_model_i.ack, gcg_host_model_i.rdData[7:0],
         dotClockEnable}, 12'h844)
      $display("channel test done");
      final_report;
   end
   // watchdog: the sequence needs well under 2000 cycles
   initial begin
      #(4000 * 50);
      error_cnt++;
      final_report;
   end
endmodule // testbench
